/* hdl/xstat_pkg.sv */
// package: register map, status-word fields and codes for extended status
package xstat_pkg;
    // register byte offsets
    localparam logic [7:0] psw_off = 8'h00;
    localparam logic [7:0] stride0_off = 8'h04;
    localparam logic [7:0] stride1_off = 8'h08;
    localparam logic [7:0] event_off = 8'h0c;
    localparam logic [7:0] flags_off = 8'h10;
    localparam logic [7:0] ctrl_off = 8'h14;
    // status-word bit positions
    localparam int sc_pos = 23;
    localparam int sqs_pos = 12;
    localparam int fin_pos = 11;
    localparam int ine_pos = 10;
    localparam int ttc_pos = 9;
    localparam int tit_pos = 8;
    localparam int cc3_pos = 7;
    localparam int cc2_pos = 6;
    localparam int cat_pos = 4;
    localparam int iec_lsb = 0;
    localparam int iec_w = 4;
    // writable status-word bits
    localparam logic [31:0] psw_wmask = 32'h0080_1fdf;
    localparam logic [31:0] psw_rst = 32'h0000_0000;
    // intrinsic error codes
    localparam logic [3:0] iec_sqrt_neg = 4'h0;
    localparam logic [3:0] iec_exp_ovf = 4'h1;
    localparam logic [3:0] iec_log_nonpos = 4'h2;
    localparam logic [3:0] iec_sin_big = 4'h6;
    localparam logic [3:0] iec_cos_big = 4'h7;
    localparam logic [3:0] iec_clear = 4'h0;
    // class code for the thread-init trace trap
    localparam logic [31:0] tit_class_code = 32'h0000_0800;
    // event register bits (write 1 = pulse)
    localparam int ev_eni = 0;
    localparam int ev_dsi = 1;
    localparam int ev_rt_eni = 2;
    localparam int ev_rt_dsi = 3;
    localparam int ev_tstvv = 4;
    localparam int ev_catack = 5;
    // flags register bits
    localparam int fl_ion = 0;
    localparam int fl_realtime_interrupt_on_flag = 1;
    localparam int fl_vv = 2;
    localparam int fl_idle = 3;
    // ctrl register: bit 0 vector-valid load value, bits 3:1 ring
    localparam int ct_vv = 0;
    localparam int ct_ring_lsb = 1;
    localparam logic [2:0] ring_kernel = 3'h0;
    localparam logic [1:0] htrans_nonseq = 2'b10;
    localparam logic [2:0] hsize_word = 3'b010;
endpackage : xstat_pkg

/* hdl/xstat_unit.sv */
// extended status word, stride registers and privileged flags
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - store ordering follows sequential-store bit
// - error flag set, code holds type
// - trap when enable and flag set
// - trace trap before and after idle
// - idle entered by wait instructions, left on fork
// - fork pickup trap writes class 0x800
// - fork-block status decides, trap in ring
// - fork trap independent of sequential mode
// - condition codes three, two writable, readable
// - bad comm address sets trap bit
// - comm trap bit held until recognized or a status-word write
// - recognition clears bit in handler frame
// - clear stale code, write new, set flag
// - untrapped errors overwrite, last one kept
// - codes sqrt 0, exp 1, log 2
// - codes sine 6, cosine 7
// - two strides give prefetch addresses
// - interrupt-on gates interrupts, set/clear instructions
// - branch variants test interrupt-on flag
// - realtime interrupt-on handled likewise
// - vector-valid load, no-op in rings 1-7
// - test copies vector-valid into scalar carry
// - scalar carry is status bit 23
module xstat_unit #(
    parameter int stride_w = 32
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // core events
    input wire logic intr_err,
    input wire logic [3:0] intr_code,
    input wire logic comm_addr_bad,
    input wire logic idle_enter,
    input wire logic fork_accept,
    input wire logic [31:0] fork_block_psw,
    input wire logic ext_irq,
    input wire logic rt_irq,
    input wire logic [31:0] effa,
    // core results
    output logic store_in_order,
    output logic fp_trap,
    output logic trace_trap,
    output logic ring_violation,
    output logic [31:0] fifth_addr_write,
    output logic fifth_addr_we,
    output logic irq_take,
    output logic rt_irq_take,
    output logic branch_ion,
    output logic [31:0] prefetch_addr_first,
    output logic [31:0] prefetch_addr_second,
    output logic hw_idle
);
    if (stride_w != 32)
    begin : g_bad_width
        $error("stride width must be 32");
    end

    // ************************************************************
    // bus slave
    // ************************************************************
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] psw_reg;
    logic [stride_w-1:0] stride0_reg;
    logic [stride_w-1:0] stride1_reg;
    logic ion_reg;
    logic realtime_interrupt_on_flag_reg;
    logic vv_reg;
    logic [2:0] ring_reg;
    logic idle_reg;
    wire take = hsel && hready && htrans == xstat_pkg::htrans_nonseq
        && hsize == xstat_pkg::hsize_word;
    wire wr = wr_pend_reg;
    wire wr_psw = wr && addr_reg == xstat_pkg::psw_off;
    wire wr_ev = wr && addr_reg == xstat_pkg::event_off;
    wire wr_ctrl = wr && addr_reg == xstat_pkg::ctrl_off;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= take && hwrite;
            if (take)
                addr_reg <= haddr[7:0];
        end
    end

    function automatic logic [31:0] read_mux(input logic [7:0] a,
        input logic [31:0] p, input logic [31:0] s0, input logic [31:0] s1,
        input logic [3:0] fl, input logic [2:0] rg);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            xstat_pkg::psw_off: r = p;
            xstat_pkg::stride0_off: r = s0;
            xstat_pkg::stride1_off: r = s1;
            xstat_pkg::flags_off: r = {28'h000_0000, fl};
            xstat_pkg::ctrl_off: r = {28'h000_0000, rg, 1'b0};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_mux

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take && !hwrite)
                hrdata <= read_mux(haddr[7:0], psw_reg, stride0_reg,
                    stride1_reg, {idle_reg, vv_reg, realtime_interrupt_on_flag_reg, ion_reg},
                    ring_reg);
        end
    end

    // ************************************************************
    // status word
    // ************************************************************
    wire ev_tstvv = wr_ev && hwdata[xstat_pkg::ev_tstvv];
    wire ev_catack = wr_ev && hwdata[xstat_pkg::ev_catack];
    wire psw_trap_word = psw_reg[xstat_pkg::ine_pos];

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            psw_reg <= xstat_pkg::psw_rst;
        else
        begin
            // software write of writable bits incl. cc3/cc2
            if (wr_psw)
                psw_reg <= (psw_reg & ~xstat_pkg::psw_wmask)
                    | (hwdata & xstat_pkg::psw_wmask);
            if (ev_tstvv)
                psw_reg[xstat_pkg::sc_pos] <= vv_reg;
            // recognition clears, a new bad address wins
            if (ev_catack)
                psw_reg[xstat_pkg::cat_pos] <= 1'b0;
            if (comm_addr_bad)
                psw_reg[xstat_pkg::cat_pos] <= 1'b1;
            // code replaced whole: stale code never merges
            if (intr_err)
            begin
                psw_reg[xstat_pkg::iec_lsb +: xstat_pkg::iec_w]
                    <= intr_code;
                psw_reg[xstat_pkg::fin_pos] <= 1'b1;
            end
        end
    end

    // ************************************************************
    // traps and idle
    // ************************************************************
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            idle_reg <= 1'b0;
        else if (fork_accept)
            idle_reg <= 1'b0;
        else if (idle_enter)
            idle_reg <= 1'b1;
    end

    wire tit_hit = fork_accept && fork_block_psw[xstat_pkg::tit_pos];
    wire ttc_hit = psw_reg[xstat_pkg::ttc_pos]
        && ((idle_enter && !idle_reg) || (fork_accept && idle_reg));

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fp_trap <= 1'b0;
            trace_trap <= 1'b0;
            ring_violation <= 1'b0;
            fifth_addr_write <= 32'h0000_0000;
            fifth_addr_we <= 1'b0;
            store_in_order <= 1'b0;
            hw_idle <= 1'b0;
        end
        else
        begin
            fp_trap <= psw_trap_word && psw_reg[xstat_pkg::fin_pos];
            // sequential mode plays no part here
            trace_trap <= ttc_hit || tit_hit;
            fifth_addr_we <= tit_hit;
            fifth_addr_write <= tit_hit ? xstat_pkg::tit_class_code
                : 32'h0000_0000;
            ring_violation <= comm_addr_bad;
            store_in_order <= psw_reg[xstat_pkg::sqs_pos];
            hw_idle <= idle_reg;
        end
    end

    // ************************************************************
    // strides and privileged flags
    // ************************************************************
    wire kernel = ring_reg == xstat_pkg::ring_kernel;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stride0_reg <= '0;
            stride1_reg <= '0;
            ring_reg <= xstat_pkg::ring_kernel;
        end
        else
        begin
            if (wr && addr_reg == xstat_pkg::stride0_off)
                stride0_reg <= hwdata[stride_w-1:0];
            if (wr && addr_reg == xstat_pkg::stride1_off)
                stride1_reg <= hwdata[stride_w-1:0];
            if (wr_ctrl)
                ring_reg <= hwdata[xstat_pkg::ct_ring_lsb +: 3];
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ion_reg <= 1'b0;
            realtime_interrupt_on_flag_reg <= 1'b0;
            vv_reg <= 1'b0;
        end
        else
        begin
            if (wr_ev && hwdata[xstat_pkg::ev_eni])
                ion_reg <= 1'b1;
            else if (wr_ev && hwdata[xstat_pkg::ev_dsi])
                ion_reg <= 1'b0;
            if (wr_ev && hwdata[xstat_pkg::ev_rt_eni])
                realtime_interrupt_on_flag_reg <= 1'b1;
            else if (wr_ev && hwdata[xstat_pkg::ev_rt_dsi])
                realtime_interrupt_on_flag_reg <= 1'b0;
            if (wr_ctrl && kernel)
                vv_reg <= hwdata[xstat_pkg::ct_vv];
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_take <= 1'b0;
            rt_irq_take <= 1'b0;
            branch_ion <= 1'b0;
            prefetch_addr_first <= 32'h0000_0000;
            prefetch_addr_second <= 32'h0000_0000;
        end
        else
        begin
            irq_take <= ext_irq && ion_reg;
            rt_irq_take <= rt_irq && realtime_interrupt_on_flag_reg;
            branch_ion <= ion_reg;
            prefetch_addr_first <= effa + stride0_reg;
            prefetch_addr_second <= effa + stride1_reg;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    a_fp_trap_cause: assert property (
        @(posedge core_clk) disable iff (!rstn)
        1'b1 |=> fp_trap == ($past(psw_reg[xstat_pkg::ine_pos])
            && $past(psw_reg[xstat_pkg::fin_pos])))
        else $error("fp trap mismatch");
    a_err_flag_set: assert property (
        @(posedge core_clk) disable iff (!rstn)
        intr_err |=> psw_reg[xstat_pkg::fin_pos]
            && psw_reg[xstat_pkg::iec_lsb +: xstat_pkg::iec_w]
            == $past(intr_code))
        else $error("intrinsic error not recorded");
    a_err_code_hold: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !intr_err && !wr_psw
            |=> $stable(psw_reg[xstat_pkg::iec_lsb +: xstat_pkg::iec_w]))
        else $error("code changed without error");
    a_cat_set: assert property (
        @(posedge core_clk) disable iff (!rstn)
        comm_addr_bad |=> psw_reg[xstat_pkg::cat_pos] && ring_violation)
        else $error("comm trap not raised");
    a_cat_sticky: assert property (
        @(posedge core_clk) disable iff (!rstn)
        psw_reg[xstat_pkg::cat_pos] && !ev_catack && !wr_psw
            |=> psw_reg[xstat_pkg::cat_pos])
        else $error("comm trap bit lost");
    a_cat_clear: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ev_catack && !comm_addr_bad |=> !psw_reg[xstat_pkg::cat_pos])
        else $error("comm trap bit not cleared");
    a_tit_code: assert property (
        @(posedge core_clk) disable iff (!rstn)
        tit_hit |=> fifth_addr_we && trace_trap
            && fifth_addr_write == xstat_pkg::tit_class_code)
        else $error("fork trap code wrong");
    a_tit_source: assert property (
        @(posedge core_clk) disable iff (!rstn)
        fifth_addr_we |-> $past(fork_accept)
            && $past(fork_block_psw[xstat_pkg::tit_pos]))
        else $error("fork trap without fork block request");
    a_ttc_trace: assert property (
        @(posedge core_clk) disable iff (!rstn)
        psw_reg[xstat_pkg::ttc_pos] && (idle_enter && !idle_reg
            || fork_accept && idle_reg) |=> trace_trap)
        else $error("thread trace trap missing");
    a_idle_enter: assert property (
        @(posedge core_clk) disable iff (!rstn)
        idle_enter && !fork_accept |=> idle_reg)
        else $error("idle not entered");
    a_idle_exit: assert property (
        @(posedge core_clk) disable iff (!rstn)
        fork_accept |=> !idle_reg ##1 !hw_idle)
        else $error("idle not left");
    a_store_order: assert property (
        @(posedge core_clk) disable iff (!rstn)
        1'b1 |=> store_in_order == $past(psw_reg[xstat_pkg::sqs_pos]))
        else $error("store ordering not followed");
    a_ion_gate: assert property (
        @(posedge core_clk) disable iff (!rstn)
        irq_take |-> $past(ion_reg) && $past(ext_irq))
        else $error("interrupt passed while off");
    a_ion_set: assert property (
        @(posedge core_clk) disable iff (!rstn)
        wr_ev && hwdata[xstat_pkg::ev_eni] |=> ion_reg)
        else $error("interrupt-on not set");
    a_branch_ion: assert property (
        @(posedge core_clk) disable iff (!rstn)
        1'b1 |=> branch_ion == $past(ion_reg))
        else $error("branch flag differs from interrupt-on");
    a_rt_gate: assert property (
        @(posedge core_clk) disable iff (!rstn)
        rt_irq_take |-> $past(realtime_interrupt_on_flag_reg) && $past(rt_irq))
        else $error("realtime interrupt passed while off");
    a_rt_set: assert property (
        @(posedge core_clk) disable iff (!rstn)
        wr_ev && hwdata[xstat_pkg::ev_rt_eni] |=> realtime_interrupt_on_flag_reg)
        else $error("realtime interrupt-on not set");
    a_pf_first: assert property (
        @(posedge core_clk) disable iff (!rstn)
        1'b1 |=> prefetch_addr_first == $past(effa) + $past(stride0_reg))
        else $error("first prefetch address wrong");
    a_pf_second: assert property (
        @(posedge core_clk) disable iff (!rstn)
        1'b1 |=> prefetch_addr_second == $past(effa) + $past(stride1_reg))
        else $error("second prefetch address wrong");
    a_vv_load: assert property (
        @(posedge core_clk) disable iff (!rstn)
        wr_ctrl && kernel |=> vv_reg == $past(hwdata[xstat_pkg::ct_vv]))
        else $error("vector valid not loaded in ring 0");
    a_vv_ring: assert property (
        @(posedge core_clk) disable iff (!rstn)
        wr_ctrl && !kernel |=> $stable(vv_reg))
        else $error("vector valid changed outside ring 0");
    a_tstvv_copy: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ev_tstvv |=> psw_reg[xstat_pkg::sc_pos] == $past(vv_reg))
        else $error("scalar carry not loaded");
    c_fp_trap: cover property (@(posedge core_clk) disable iff (!rstn)
        intr_err && psw_reg[10] ##2 fp_trap);
    c_tit: cover property (@(posedge core_clk) disable iff (!rstn) tit_hit);
    c_idle_cycle: cover property (@(posedge core_clk) disable iff (!rstn)
        idle_enter ##[1:20] fork_accept);
    c_cat: cover property (@(posedge core_clk) disable iff (!rstn)
        comm_addr_bad ##[1:20] ev_catack);
endmodule : xstat_unit
`default_nettype wire

/* test/xstat_unit_tb.sv */
// self-checking bench for the extended status unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("wrong value %s exp %h got %h", n, e, g); \
        end \
    end
module extended_status_and_trap_flags_tb_top;
    // ****
    // stimulus and results
    // ****
    int n_errors = 0;
    int tests_run = 0;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q, a5;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    wire logic hready;
    logic hreadyout, hresp, intr_err = 1'b0, comm_addr_bad = 1'b0;
    logic idle_enter = 1'b0, fork_accept = 1'b0;
    logic ext_irq = 1'b0, rt_irq = 1'b0;
    logic [3:0] intr_code = 4'h0, seen;
    logic [31:0] fork_block_psw = '0, effa = '0;
    logic store_in_order, fp_trap, trace_trap, ring_violation;
    logic [31:0] fifth_addr_write, prefetch_addr_first;
    logic [31:0] prefetch_addr_second;
    logic fifth_addr_we, irq_take, rt_irq_take, branch_ion, hw_idle;
    logic [3:0] codes [5] = '{4'h7, 4'h6, 4'h1, 4'h2, 4'h0};
    logic [3:0] evs [5] = '{4'h0, 4'h1, 4'h4, 4'h2, 4'h8};
    logic [3:0] fls [5] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h0};
    assign hready = hreadyout;
    always #5 core_clk = ~core_clk;
    xstat_unit xstat_unit_i (
        .core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .intr_err,
        .intr_code, .comm_addr_bad, .idle_enter, .fork_accept,
        .fork_block_psw, .ext_irq, .rt_irq, .effa, .store_in_order,
        .fp_trap, .trace_trap, .ring_violation, .fifth_addr_write,
        .fifth_addr_we, .irq_take, .rt_irq_take, .branch_ion,
        .prefetch_addr_first, .prefetch_addr_second, .hw_idle
    );
    // ****
    // bus and event tasks
    // ****
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= xstat_pkg::htrans_nonseq;
        hwrite <= w;
        hsize <= xstat_pkg::hsize_word;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (hready !== 1'b1 && n < 9);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (hready !== 1'b1 && n < 18);
        q = hrdata;
        if (hready !== 1'b1)
        begin
            n_errors++;
            test_done();
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e,
        input string s);
        bus(1'b0, a, 32'h0);
        `CHK(s, e, q)
    endtask : rc
    // event inputs are set by the caller; this ends and watches them
    task automatic watch;
        seen = 4'h0;
        a5 = 32'h0;
        @(posedge core_clk);
        intr_err <= 1'b0;
        comm_addr_bad <= 1'b0;
        idle_enter <= 1'b0;
        fork_accept <= 1'b0;
        repeat (4)
        begin
            @(posedge core_clk);
            seen |= {trace_trap, fifth_addr_we, ring_violation, fp_trap};
            if (fifth_addr_we === 1'b1)
                a5 = fifth_addr_write;
        end
    endtask : watch
    // ****
    // tests
    // ****
    initial
    begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 7; i++)
            rc(8'(i * 4), 32'h0, "reset reg");
        `CHK("hresp", 1'b0, hresp)
        $display("test reset done");
        wr(8'h00, 32'hffff_ffff);
        wr(8'h10, 32'hf);
        wr(8'h40, 32'h1);
        rc(8'h00, xstat_pkg::psw_wmask, "psw mask");
        rc(8'h10, 32'h0, "flags ro");
        rc(8'h40, 32'h0, "unmapped");
        `CHK("in order", 1'b1, store_in_order)
        `CHK("fp trap", 1'b1, fp_trap)
        wr(8'h00, 32'h0);
        repeat (3) @(posedge core_clk);
        `CHK("in order", 1'b0, store_in_order)
        `CHK("fp trap", 1'b0, fp_trap)
        $display("test psw done");
        foreach (codes[i])
        begin
            intr_err <= 1'b1;
            intr_code <= codes[i];
            watch();
            `CHK("no trap", 1'b0, seen[0])
            rc(8'h00, 32'h800 | 32'(codes[i]), "iec");
        end
        wr(8'h00, 32'h400);
        intr_code <= xstat_pkg::iec_cos_big;
        intr_err <= 1'b1;
        watch();
        `CHK("trap", 1'b1, seen[0])
        rc(8'h00, 32'hc07, "iec trap");
        $display("test intrinsic done");
        wr(8'h04, 32'h100);
        wr(8'h08, 32'hffff_f000);
        effa <= 32'h2000;
        repeat (3) @(posedge core_clk);
        `CHK("pf first", 32'h2100, prefetch_addr_first)
        `CHK("pf second", 32'h1000, prefetch_addr_second)
        rc(8'h08, 32'hffff_f000, "stride");
        $display("test stride done");
        wr(8'h00, 32'h0);
        comm_addr_bad <= 1'b1;
        watch();
        `CHK("ring viol", 1'b1, seen[1])
        wr(8'h14, 32'h8);
        rc(8'h00, 32'h10, "cat held");
        wr(8'h0c, 32'h20);
        rc(8'h00, 32'h0, "cat clear");
        wr(8'h14, 32'h0);
        $display("test comm done");
        wr(8'h00, 32'h200);
        idle_enter <= 1'b1;
        watch();
        `CHK("trace in", 4'h8, seen)
        `CHK("hw idle", 1'b1, hw_idle)
        rc(8'h10, 32'h8, "idle");
        fork_block_psw <= 32'h100;
        fork_accept <= 1'b1;
        watch();
        `CHK("trace out", 4'hc, seen)
        `CHK("a5", xstat_pkg::tit_class_code, a5)
        rc(8'h10, 32'h0, "left idle");
        wr(8'h00, 32'h100);
        fork_block_psw <= 32'h0;
        fork_accept <= 1'b1;
        watch();
        `CHK("own tit", 4'h0, seen)
        wr(8'h00, 32'h0);
        fork_block_psw <= 32'h100;
        fork_accept <= 1'b1;
        watch();
        `CHK("block tit", 4'hc, seen)
        idle_enter <= 1'b1;
        watch();
        `CHK("no trace", 4'h0, seen)
        $display("test thread done");
        ext_irq <= 1'b1;
        rt_irq <= 1'b1;
        foreach (evs[i])
        begin
            wr(8'h0c, 32'(evs[i]));
            repeat (3) @(posedge core_clk);
            `CHK("irq", fls[i][0], irq_take)
            `CHK("rt irq", fls[i][1], rt_irq_take)
            `CHK("branch", fls[i][0], branch_ion)
            rc(8'h10, 32'(fls[i]) | 32'h8, "flags");
        end
        $display("test irq done");
        wr(8'h14, 32'h5);
        wr(8'h0c, 32'h10);
        rc(8'h00, 32'h0080_0000, "carry");
        wr(8'h14, 32'h4);
        wr(8'h14, 32'h0);
        rc(8'h10, 32'hc, "vv kept");
        wr(8'h14, 32'h0);
        wr(8'h0c, 32'h10);
        rc(8'h10, 32'h8, "vv off");
        rc(8'h00, 32'h0, "carry off");
        $display("test vector done");
        test_done();
    end
endmodule : extended_status_and_trap_flags_tb_top
`default_nettype wire
